// *** common/cms_cfg.svh ***
// Operation
// - Interrupt abandons load or store multiple
// - Interrupt abandons iterative multiply in progress
// - Abandoned instruction restarts from first step
// - Mask bit via move and state-change
// - Mask bit blocks configurable-priority exception activation
// - Stack-select bit one selects process stack
// - Handler mode reads zero, ignores writes
// - Handler mode always uses main stack
// - Exception entry and return update select
// - Reset uses main; write one selects process
// - All exceptions but reset in Handler mode
// - Fetch and peripheral-bus accesses little-endian
// - Reset clears mask and select registers
// - Reset loads main stack from address zero
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH
// ----------------------------------------
// Special register selectors
// ----------------------------------------
`define CMS_SEL_MASK      1'b0
`define CMS_SEL_STACK     1'b1
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CMS_MASK_BIT      0
`define CMS_STACK_BIT     1
`define CMS_RESET_VALUE   32'h0000_0000
`define CMS_SP_VECTOR     32'h0000_0000
`define CMS_BIG_ENDIAN    1'b0
`define CMS_MUL_CYCLES    6'h20
`endif

// *** common/cms_pkg.sv ***
package cms_pkg;
   typedef enum logic [1:0] {
      CMS_RESET_FETCH,
      CMS_RESET_WAIT,
      CMS_RUN
   } cms_boot_t;
endpackage : cms_pkg

// *** rtl/cms_mul_seq.sv ***
`timescale 1ns/10ps
`include "cms_cfg.svh"
// ----------------------------------------
// Iterative multiplier sequencer, abandonable
// ----------------------------------------
module cms_mul_seq
   import cms_pkg::*;
#(
   parameter logic [5:0] CYCLES = `CMS_MUL_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic       abandon,
   output logic            busy,
   output logic            done
);
   typedef struct packed {
      logic       busy;
      logic       done;
      logic [5:0] cnt;
   } cms_mul_state_t;

   cms_mul_state_t st_r;
   cms_mul_state_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      if (st_r.busy && abandon) begin
         st_nxt.busy = 1'b0;
         st_nxt.cnt  = 6'h00;
      end else if (st_r.busy) begin
         if (st_r.cnt == CYCLES - 6'h01) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.cnt  = 6'h00;
         end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
         end
      end else if (start && !abandon) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt  = 6'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = st_r.busy;
   assign done = st_r.done;

   property p_mul_abandon;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.busy && abandon) |=> (!st_r.busy && !st_r.done);
   endproperty
   a_mul_abandon: assert property (p_mul_abandon) else $error("multiply not abandoned");
endmodule : cms_mul_seq

// *** rtl/cms_core_state.sv ***
`timescale 1ns/10ps
`include "cms_cfg.svh"
module cms_core_state
   import cms_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Special register moves
   input  wire logic        msr_valid,
   input  wire logic        msr_sel,
   input  wire logic [31:0] msr_data,
   input  wire logic        mrs_sel,
   // State change instruction
   input  wire logic        cps_valid,
   input  wire logic        cps_disable,
   // Exception sequencing
   input  wire logic        exc_req,
   input  wire logic        exc_req_configurable,
   input  wire logic        exc_entry,
   input  wire logic        exc_return,
   input  wire logic        exc_ret_stack,
   // Instruction in flight
   input  wire logic        irq_arrive,
   input  wire logic        multi_busy,
   input  wire logic        mul_start,
   input  wire logic [31:0] instr_addr,
   // Reset vector fetch
   input  wire logic        vec_ack,
   input  wire logic [31:0] vec_data,
   // Outputs
   output logic [31:0]      mrs_data,
   output logic             exc_activate,
   output logic             handler_mode,
   output logic             use_process_sp,
   output logic             abandon,
   output logic [31:0]      return_addr,
   output logic             mul_busy,
   output logic             mul_done,
   output logic             vec_req,
   output logic [31:0]      vec_addr,
   output logic [31:0]      main_sp_init,
   output logic             main_sp_load,
   output logic             fetch_big_endian
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      cms_boot_t   boot;
      logic        mask;
      logic        stack_sel;
      logic        handler;
      logic [31:0] mrs_data;
      logic        exc_act;
      logic        use_psp;
      logic        abandon;
      logic [31:0] ret_addr;
      logic        vec_req;
      logic [31:0] sp_init;
      logic        sp_load;
      logic [31:0] vec_addr;
      logic        big_end;
   } cms_state_t;

   cms_state_t st_r;
   cms_state_t st_nxt;
   logic       mul_busy_w;
   logic       mul_done_w;
   logic       irq_hit;

   cms_mul_seq u_mul (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .start   (mul_start),
      .abandon (irq_arrive),
      .busy    (mul_busy_w),
      .done    (mul_done_w)
   );

   assign irq_hit = irq_arrive && (multi_busy || mul_busy_w);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.sp_load = 1'b0;
      st_nxt.abandon = 1'b0;
      case (st_r.boot)
         CMS_RESET_FETCH: begin
            st_nxt.vec_req = 1'b1;
            st_nxt.boot    = CMS_RESET_WAIT;
         end
         CMS_RESET_WAIT: begin
            if (vec_ack) begin
               st_nxt.vec_req = 1'b0;
               st_nxt.sp_init = vec_data;
               st_nxt.sp_load = 1'b1;
               st_nxt.boot    = CMS_RUN;
            end
         end
         CMS_RUN: begin
            if (msr_valid && msr_sel == `CMS_SEL_MASK) begin
               st_nxt.mask = msr_data[`CMS_MASK_BIT];
            end
            if (cps_valid) begin
               st_nxt.mask = cps_disable;
            end
            if (msr_valid && msr_sel == `CMS_SEL_STACK && !st_r.handler) begin
               st_nxt.stack_sel = msr_data[`CMS_STACK_BIT];
            end
            if (irq_hit) begin
               st_nxt.abandon  = 1'b1;
               st_nxt.ret_addr = instr_addr;
            end
            if (exc_return) begin
               st_nxt.handler   = 1'b0;
               st_nxt.stack_sel = exc_ret_stack;
            end
            if (exc_entry) begin
               st_nxt.handler   = 1'b1;
               st_nxt.stack_sel = 1'b0;
            end
         end
         default: st_nxt.boot = CMS_RESET_FETCH;
      endcase
      st_nxt.exc_act  = exc_req && !(exc_req_configurable && st_r.mask);
      st_nxt.use_psp  = st_nxt.stack_sel && !st_nxt.handler;
      st_nxt.vec_addr = `CMS_SP_VECTOR;
      st_nxt.big_end  = `CMS_BIG_ENDIAN;
      st_nxt.mrs_data = `CMS_RESET_VALUE;
      if (mrs_sel == `CMS_SEL_MASK) begin
         st_nxt.mrs_data[`CMS_MASK_BIT] = st_nxt.mask;
      end else begin
         st_nxt.mrs_data[`CMS_STACK_BIT] = st_nxt.stack_sel && !st_nxt.handler;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_r      <= '0;
         st_r.boot <= CMS_RESET_FETCH;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mrs_data         = st_r.mrs_data;
   assign exc_activate     = st_r.exc_act;
   assign handler_mode     = st_r.handler;
   assign use_process_sp   = st_r.use_psp;
   assign abandon          = st_r.abandon;
   assign return_addr      = st_r.ret_addr;
   assign mul_busy         = mul_busy_w;
   assign mul_done         = mul_done_w;
   assign vec_req          = st_r.vec_req;
   assign vec_addr         = st_r.vec_addr;
   assign main_sp_init     = st_r.sp_init;
   assign main_sp_load     = st_r.sp_load;
   assign fetch_big_endian = st_r.big_end;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_irq_on_multi;
      st_r.boot == CMS_RUN && irq_arrive && multi_busy;
   endsequence

   property p_abandon;
      @(posedge ref_clk) disable iff (!resetn)
         s_irq_on_multi |=> abandon;
   endproperty
   a_abandon: assert property (p_abandon) else $error("transfer not abandoned");

   property p_restart_addr;
      @(posedge ref_clk) disable iff (!resetn)
         s_irq_on_multi |=> (return_addr == $past(instr_addr));
   endproperty
   a_restart_addr: assert property (p_restart_addr) else $error("bad return address");

   property p_mask_block;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.mask && exc_req && exc_req_configurable) |=> !exc_activate;
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked exception activated");

   property p_mask_free;
      @(posedge ref_clk) disable iff (!resetn)
         (!st_r.mask && exc_req) |=> exc_activate;
   endproperty
   a_mask_free: assert property (p_mask_free) else $error("unmasked exception held");

   property p_handler_msp;
      @(posedge ref_clk) disable iff (!resetn)
         handler_mode |-> !use_process_sp;
   endproperty
   a_handler_msp: assert property (p_handler_msp) else $error("handler on process stack");

   property p_handler_read;
      @(posedge ref_clk) disable iff (!resetn)
         (st_nxt.handler && mrs_sel == `CMS_SEL_STACK) |=> (mrs_data == 32'h0000_0000);
   endproperty
   a_handler_read: assert property (p_handler_read) else $error("handler read nonzero");

   property p_cps;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RUN && cps_valid) |=> (st_r.mask == $past(cps_disable));
   endproperty
   a_cps: assert property (p_cps) else $error("state change ignored");

   property p_entry;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RUN && exc_entry) |=> (handler_mode && !st_r.stack_sel);
   endproperty
   a_entry: assert property (p_entry) else $error("entry did not enter handler");

   property p_boot;
      @(posedge ref_clk) $rose(resetn) |-> ##[1:2] vec_req;
   endproperty
   a_boot: assert property (p_boot) else $error("no vector fetch");

   // ----------------------------------------
   // Stack select checks
   // ----------------------------------------
   sequence s_thread_stack_wr;
      st_r.boot == CMS_RUN && msr_valid && msr_sel == `CMS_SEL_STACK && !st_r.handler
         && !exc_entry && !exc_return;
   endsequence

   sequence s_handler_stack_wr;
      st_r.boot == CMS_RUN && msr_valid && msr_sel == `CMS_SEL_STACK && st_r.handler
         && !exc_entry && !exc_return;
   endsequence

   property p_stack_write;
      @(posedge ref_clk) disable iff (!resetn)
         s_thread_stack_wr |=> (use_process_sp == $past(msr_data[`CMS_STACK_BIT]));
   endproperty
   a_stack_write: assert property (p_stack_write) else $error("stack write lost");

   property p_handler_write;
      @(posedge ref_clk) disable iff (!resetn)
         s_handler_stack_wr |=> (st_r.stack_sel == $past(st_r.stack_sel));
   endproperty
   a_handler_write: assert property (p_handler_write) else $error("handler write taken");

   property p_thread_select;
      @(posedge ref_clk) disable iff (!resetn)
         (!handler_mode) |-> (use_process_sp == st_r.stack_sel);
   endproperty
   a_thread_select: assert property (p_thread_select) else $error("wrong thread stack");

   property p_stack_read;
      @(posedge ref_clk) disable iff (!resetn)
         (mrs_sel == `CMS_SEL_STACK) |=> (mrs_data == {30'h0, use_process_sp, 1'b0});
   endproperty
   a_stack_read: assert property (p_stack_read) else $error("stack read bad");

   property p_return;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RUN && exc_return && !exc_entry)
            |=> (!handler_mode && st_r.stack_sel == $past(exc_ret_stack));
   endproperty
   a_return: assert property (p_return) else $error("return did not restore");

   // ----------------------------------------
   // Mask and multiply checks
   // ----------------------------------------
   property p_mask_write;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RUN && msr_valid && msr_sel == `CMS_SEL_MASK && !cps_valid)
            |=> (st_r.mask == $past(msr_data[`CMS_MASK_BIT]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   property p_mask_read;
      @(posedge ref_clk) disable iff (!resetn)
         (mrs_sel == `CMS_SEL_MASK) |=> (mrs_data == {31'h0, st_r.mask});
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read bad");

   property p_mul_irq;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RUN && irq_arrive && mul_busy_w) |=> (abandon && !mul_busy_w);
   endproperty
   a_mul_irq: assert property (p_mul_irq) else $error("multiply kept running");

   // ----------------------------------------
   // Reset and boot checks
   // ----------------------------------------
   property p_reset_clear;
      @(posedge ref_clk) !resetn |=> (!st_r.mask && !st_r.stack_sel && mrs_data == 32'h0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

   property p_boot_quiet;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot != CMS_RUN) |=> (!st_r.mask && !use_process_sp && !handler_mode);
   endproperty
   a_boot_quiet: assert property (p_boot_quiet) else $error("state moved before boot");

   property p_vec_load;
      @(posedge ref_clk) disable iff (!resetn)
         (st_r.boot == CMS_RESET_WAIT && vec_ack)
            |=> (main_sp_load && main_sp_init == $past(vec_data));
   endproperty
   a_vec_load: assert property (p_vec_load) else $error("stack vector not loaded");

   property p_vec_hold;
      @(posedge ref_clk) disable iff (!resetn)
         (vec_req && !vec_ack) |=> vec_req;
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector request dropped");

   property p_sp_load_once;
      @(posedge ref_clk) disable iff (!resetn)
         main_sp_load |=> !main_sp_load;
   endproperty
   a_sp_load_once: assert property (p_sp_load_once) else $error("stack loaded twice");
endmodule : cms_core_state

// *** testbench/test_core_mask_and_stack_select.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module test_core_mask_and_stack_select;
   import cms_pkg::*;
   logic        ref_clk, resetn, msr_valid, msr_sel, mrs_sel, cps_valid, cps_disable;
   logic        exc_req, exc_req_configurable, exc_entry, exc_return, exc_ret_stack;
   logic        irq_arrive, multi_busy, mul_start, vec_ack;
   logic [31:0] msr_data, instr_addr, vec_data, mrs_data, return_addr, vec_addr;
   logic [31:0] main_sp_init;
   logic        exc_activate, handler_mode, use_process_sp, abandon, mul_busy;
   logic        mul_done, vec_req, main_sp_load, fetch_big_endian;
   int          n_mismatch, checks_done, cnt;

   cms_core_state dut_u (.ref_clk, .resetn, .msr_valid, .msr_sel, .msr_data, .mrs_sel,
      .cps_valid, .cps_disable, .exc_req, .exc_req_configurable, .exc_entry, .exc_return,
      .exc_ret_stack, .irq_arrive, .multi_busy, .mul_start, .instr_addr, .vec_ack,
      .vec_data, .mrs_data, .exc_activate, .handler_mode, .use_process_sp, .abandon,
      .return_addr, .mul_busy, .mul_done, .vec_req, .vec_addr, .main_sp_init,
      .main_sp_load, .fetch_big_endian);

   // ----------------------------------------
   // Clock and access tasks
   // ----------------------------------------
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic msr_wr(input logic sel, input logic [31:0] d);
      cyc(1);
      msr_valid <= 1'b1;
      msr_sel   <= sel;
      msr_data  <= d;
      cyc(1);
      msr_valid <= 1'b0;
      #1;
   endtask : msr_wr

   task automatic mrs_rd(input logic sel, output logic [31:0] d);
      cyc(1);
      mrs_sel <= sel;
      cyc(2);
      #1;
      d = mrs_data;
   endtask : mrs_rd

   task automatic end_sim;
      if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [31:0] rd;
      {resetn, msr_valid, msr_sel, mrs_sel, cps_valid, cps_disable} = '0;
      {exc_req, exc_req_configurable, exc_entry, exc_return, exc_ret_stack} = '0;
      {irq_arrive, multi_busy, mul_start, vec_ack} = '0;
      {msr_data, instr_addr, vec_data} = '0;
      n_mismatch = 0;
      checks_done = 0;
      cyc(3);
      #1;
      `CHK({vec_req, handler_mode, abandon}, 3'h0)
      cyc(1);
      resetn <= 1'b1;
      cnt = 0;
      while (vec_req !== 1'b1 && cnt < 10) begin
         cyc(1);
         #1;
         cnt++;
      end
      if (cnt == 10) begin
         n_mismatch++;
         end_sim();
      end
      `CHK(vec_addr, 32'h0000_0000)
      cyc(1);
      vec_data <= 32'h2000_0400;
      vec_ack  <= 1'b1;
      cyc(1);
      vec_ack  <= 1'b0;
      #1;
      `CHK({main_sp_load, main_sp_init}, {1'b1, 32'h2000_0400})
      `CHK(fetch_big_endian, 1'b0)
      mrs_rd(1'b0, rd);
      `CHK(rd, 32'h0000_0000)
      mrs_rd(1'b1, rd);
      `CHK({rd, use_process_sp}, {32'h0000_0000, 1'b0})
      msr_wr(1'b1, 32'hffff_ffff);
      cyc(1);
      #1;
      `CHK(use_process_sp, 1'b1)
      mrs_rd(1'b1, rd);
      `CHK(rd, 32'h0000_0002)
      msr_wr(1'b0, 32'hffff_ffff);
      mrs_rd(1'b0, rd);
      `CHK(rd, 32'h0000_0001)
      cyc(1);
      exc_req <= 1'b1;
      exc_req_configurable <= 1'b1;
      cyc(2);
      #1;
      `CHK(exc_activate, 1'b0)
      cyc(1);
      exc_req_configurable <= 1'b0;
      cyc(2);
      #1;
      `CHK(exc_activate, 1'b1)
      cyc(1);
      exc_req_configurable <= 1'b1;
      cps_valid   <= 1'b1;
      cps_disable <= 1'b0;
      cyc(1);
      cps_valid <= 1'b0;
      cyc(1);
      #1;
      `CHK(exc_activate, 1'b1)
      cyc(1);
      exc_req <= 1'b0;
      exc_entry <= 1'b1;
      cyc(1);
      exc_entry <= 1'b0;
      #1;
      `CHK({handler_mode, use_process_sp}, 2'h2)
      msr_wr(1'b1, 32'hffff_ffff);
      mrs_rd(1'b1, rd);
      `CHK({rd, use_process_sp}, {32'h0000_0000, 1'b0})
      cyc(1);
      exc_ret_stack <= 1'b1;
      exc_return    <= 1'b1;
      cyc(1);
      exc_return <= 1'b0;
      #1;
      `CHK({handler_mode, use_process_sp}, 2'h1)
      cyc(1);
      multi_busy <= 1'b1;
      instr_addr <= 32'h0000_1234;
      irq_arrive <= 1'b1;
      cyc(1);
      irq_arrive <= 1'b0;
      multi_busy <= 1'b0;
      #1;
      `CHK({abandon, return_addr}, {1'b1, 32'h0000_1234})
      cyc(1);
      mul_start <= 1'b1;
      cyc(1);
      mul_start <= 1'b0;
      cyc(4);
      irq_arrive <= 1'b1;
      cyc(1);
      irq_arrive <= 1'b0;
      #1;
      `CHK({mul_busy, abandon}, 2'h1)
      cyc(1);
      mul_start <= 1'b1;
      cyc(1);
      mul_start <= 1'b0;
      cnt = 0;
      while (mul_done !== 1'b1 && cnt < 40) begin
         cyc(1);
         #1;
         cnt++;
      end
      `CHK(cnt, 32)
      msr_wr(1'b0, 32'h0000_0001);
      cyc(1);
      resetn <= 1'b0;
      cyc(2);
      resetn <= 1'b1;
      mrs_rd(1'b0, rd);
      `CHK(rd, 32'h0000_0000)
      mrs_rd(1'b1, rd);
      `CHK({rd, use_process_sp, vec_req}, {32'h0000_0000, 2'h1})
      end_sim();
   end
endmodule : test_core_mask_and_stack_select
